/* File: verilog/erw_rx_watermark_irq.sv */
`timescale 1ns/1ps
`default_nettype none
module erw_rx_watermark_irq (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  // AXI4-Lite write
  input  wire logic [7:0]  awaddr_in,
  input  wire logic        awvalid_in,
  output logic             awready_out,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wstrb_in,
  input  wire logic        wvalid_in,
  output logic             wready_out,
  output logic [1:0]       bresp_out,
  output logic             bvalid_out,
  input  wire logic        bready_in,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr_in,
  input  wire logic        arvalid_in,
  output logic             arready_out,
  output logic [31:0]      rdata_out,
  output logic [1:0]       rresp_out,
  output logic             rvalid_out,
  input  wire logic        rready_in,
  // DMA and MAC events
  input  wire logic        rx_pkt_done_in,
  input  wire logic [7:0]  rx_desc_used_in,
  input  wire logic        rx_activity_in,
  input  wire logic        rx_desc_missing_in,
  input  wire logic        rx_overflow_in,
  input  wire logic        rx_bus_error_in,
  input  wire logic        tx_bus_error_in,
  input  wire logic        tx_done_in,
  input  wire logic        tx_abort_in,
  input  wire logic        rx_count_clear_in,
  // Outputs to the controller
  output logic [7:0]       rx_buffer_count_out,
  output logic             flow_control_out,
  output logic             rx_halt_out,
  output logic             irq_out
);
  logic [31:0] wm_r;
  logic [31:0] wm_nxt;
  logic [31:0] en_r;
  logic [31:0] en_nxt;
  logic [31:0] req_r;
  logic [31:0] req_nxt;
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic        fc_r;
  logic        fc_nxt;
  logic        wr_en_w;
  logic [7:0]  wr_addr_w;
  logic [31:0] wr_data_w;
  logic [3:0]  wr_strb_w;
  logic        wr_ok_w;
  logic [7:0]  rd_addr_w;
  logic [31:0] rd_data_w;
  logic        rd_ok_w;
  logic [7:0]  cnt_w;
  logic [7:0]  fwm_w;
  logic [7:0]  ewm_w;
  logic        full_cond_w;
  logic        empty_cond_w;
  logic        dec_w;
  logic        wr_wm_w;
  logic        wr_en_reg_w;
  logic        wr_req_w;
  logic        wr_ctrl_w;
  logic [31:0] evt_w;
  logic [31:0] req_sw_w;
  logic [31:0] hw_w;

  // Register select ignoring alias bits
  function automatic logic sel(input logic [7:0] a, input logic [7:0] base);
    sel = (a[7:4] == base[7:4]);
  endfunction : sel

  // Apply alias operation under byte strobes
  function automatic logic [31:0] apply(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0]  strb,
    input logic [1:0]  op
  );
    logic [31:0] m;
    logic [31:0] d;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    d = data & m;
    unique case (op)
      erw_pkg::ALIAS_WRITE: apply = (old & ~m) | d;
      erw_pkg::ALIAS_SET:   apply = old | d;
      erw_pkg::ALIAS_CLR:   apply = old & ~d;
      erw_pkg::ALIAS_INV:   apply = old ^ d;
    endcase
  endfunction : apply

  erw_axil_slave u_bus (
    .clk_sys_in  (clk_sys_in),
    .resetn_in   (resetn_in),
    .awaddr_in   (awaddr_in),
    .awvalid_in  (awvalid_in),
    .awready_out (awready_out),
    .wdata_in    (wdata_in),
    .wstrb_in    (wstrb_in),
    .wvalid_in   (wvalid_in),
    .wready_out  (wready_out),
    .bresp_out   (bresp_out),
    .bvalid_out  (bvalid_out),
    .bready_in   (bready_in),
    .araddr_in   (araddr_in),
    .arvalid_in  (arvalid_in),
    .arready_out (arready_out),
    .rdata_out   (rdata_out),
    .rresp_out   (rresp_out),
    .rvalid_out  (rvalid_out),
    .rready_in   (rready_in),
    .wr_en_out   (wr_en_w),
    .wr_addr_out (wr_addr_w),
    .wr_data_out (wr_data_w),
    .wr_strb_out (wr_strb_w),
    .wr_ok_in    (wr_ok_w),
    .rd_addr_out (rd_addr_w),
    .rd_data_in  (rd_data_w),
    .rd_ok_in    (rd_ok_w)
  );

  // Write decode
  assign wr_wm_w     = wr_en_w && sel(wr_addr_w, erw_pkg::OFF_WM);
  assign wr_en_reg_w = wr_en_w && sel(wr_addr_w, erw_pkg::OFF_EN);
  assign wr_req_w    = wr_en_w && sel(wr_addr_w, erw_pkg::OFF_REQ);
  assign wr_ctrl_w   = wr_en_w && sel(wr_addr_w, erw_pkg::OFF_CTRL);
  assign wr_ok_w     = wr_wm_w || wr_en_reg_w || wr_req_w || wr_ctrl_w;
  // Decrement strobe is a write-one action bit
  assign dec_w = wr_ctrl_w && wr_strb_w[0] && wr_data_w[erw_pkg::CTRL_DEC]
                 && wr_addr_w[3:2] != erw_pkg::ALIAS_CLR;

  erw_buf_counter u_cnt (
    .clk_sys_in    (clk_sys_in),
    .resetn_in     (resetn_in),
    .inc_in        (rx_pkt_done_in),
    .inc_amount_in (rx_desc_used_in),
    .dec_in        (dec_w),
    .clear_in      (rx_count_clear_in),
    .count_out     (cnt_w)
  );

  // Watermark comparison
  assign fwm_w        = wm_r[erw_pkg::FWM_LSB +: 8];
  assign ewm_w        = wm_r[erw_pkg::EWM_LSB +: 8];
  assign full_cond_w  = cnt_w >= fwm_w;
  assign empty_cond_w = cnt_w <= ewm_w;

  // Register next values
  assign wm_nxt = wr_wm_w ? apply(wm_r, wr_data_w, wr_strb_w, wr_addr_w[3:2])
                  & erw_pkg::WM_MASK : wm_r;
  assign en_nxt = wr_en_reg_w ? apply(en_r, wr_data_w, wr_strb_w, wr_addr_w[3:2])
                  & erw_pkg::FLAG_MASK : en_r;
  assign ctrl_nxt = wr_ctrl_w ? apply(ctrl_r, wr_data_w, wr_strb_w, wr_addr_w[3:2])
                    & erw_pkg::CTRL_MASK : ctrl_r;

  // Event inputs at their flag positions
  always_comb
  begin
    evt_w = 32'h00000000;
    evt_w[erw_pkg::B_TX_BUS_ERROR_FLAG]  = tx_bus_error_in;
    evt_w[erw_pkg::B_RX_BUS_ERROR_FLAG]  = rx_bus_error_in;
    evt_w[erw_pkg::B_RX_DONE_FLAG]  = rx_pkt_done_in;
    evt_w[erw_pkg::B_RX_ACTIVITY_FLAG]   = rx_activity_in;
    evt_w[erw_pkg::B_TX_DONE_FLAG]  = tx_done_in;
    evt_w[erw_pkg::B_TX_ABORT_FLAG] = tx_abort_in;
    evt_w[erw_pkg::B_RX_DESCRIPTOR_MISSING_FLAG] = rx_desc_missing_in;
    evt_w[erw_pkg::B_RX_OVERFLOW_FLAG] = rx_overflow_in;
  end

  // Hardware-owned flags, writes ignored, clearing event wins
  always_comb
  begin
    hw_w = 32'h00000000;
    hw_w[erw_pkg::B_FULL_MARK_FLAG] = !dec_w
      && (full_cond_w || req_r[erw_pkg::B_FULL_MARK_FLAG]);
    hw_w[erw_pkg::B_EMPTY_MARK_FLAG] = !rx_pkt_done_in
      && (empty_cond_w || req_r[erw_pkg::B_EMPTY_MARK_FLAG]);
    hw_w[erw_pkg::B_PACKET_PENDING_FLAG] = !dec_w
      && ((cnt_w != erw_pkg::CNT_RST) || req_r[erw_pkg::B_PACKET_PENDING_FLAG]);
  end

  // Software alias on event flags, a new event wins
  assign req_sw_w = wr_req_w ? apply(req_r, wr_data_w, wr_strb_w, wr_addr_w[3:2])
                    : req_r;
  assign req_nxt  = ((req_sw_w | evt_w) & erw_pkg::EVT_MASK) | hw_w;

  // Automatic flow control follows the watermarks
  always_comb
  begin
    fc_nxt = fc_r;
    if (!ctrl_r[erw_pkg::CTRL_AUTOFC])
      fc_nxt = 1'b0;
    else if (full_cond_w)
      fc_nxt = 1'b1;
    else if (empty_cond_w)
      fc_nxt = 1'b0;
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wm_r   <= erw_pkg::WM_RST;
      en_r   <= erw_pkg::EN_RST;
      req_r  <= erw_pkg::REQ_RST;
      ctrl_r <= erw_pkg::CTRL_RST;
      fc_r   <= 1'b0;
    end
    else
    begin
      wm_r   <= wm_nxt;
      en_r   <= en_nxt;
      req_r  <= req_nxt;
      ctrl_r <= ctrl_nxt;
      fc_r   <= fc_nxt;
    end
  end

  // Read mux, reserved bits already zero in storage
  always_comb
  begin
    rd_data_w = 32'h00000000;
    rd_ok_w   = 1'b1;
    if (sel(rd_addr_w, erw_pkg::OFF_WM))
      rd_data_w = wm_r & erw_pkg::WM_MASK;
    else if (sel(rd_addr_w, erw_pkg::OFF_EN))
      rd_data_w = en_r & erw_pkg::FLAG_MASK;
    else if (sel(rd_addr_w, erw_pkg::OFF_REQ))
      rd_data_w = req_r & erw_pkg::FLAG_MASK;
    else if (sel(rd_addr_w, erw_pkg::OFF_CTRL))
      rd_data_w = ctrl_r;
    else if (sel(rd_addr_w, erw_pkg::OFF_STAT))
      rd_data_w[erw_pkg::STAT_CNT_LSB +: 8] = cnt_w;
    else
      rd_ok_w = 1'b0;
  end

  // Outputs
  assign rx_buffer_count_out = cnt_w;
  assign flow_control_out    = fc_r;
  assign rx_halt_out         = ctrl_r[erw_pkg::CTRL_AUTOFC] && cnt_w == erw_pkg::CNT_MAX;
  assign irq_out             = |(req_r & en_r);

  // Checks
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);

  a_full_mark_set: assert property (
    cnt_w >= fwm_w && !dec_w |=> req_r[erw_pkg::B_FULL_MARK_FLAG])
    else $error("full mark flag missed");

  a_full_mark_clear: assert property (
    dec_w |=> !req_r[erw_pkg::B_FULL_MARK_FLAG])
    else $error("full mark flag kept over decrement");

  a_full_mark_hold: assert property (
    req_r[erw_pkg::B_FULL_MARK_FLAG] && !dec_w |=> req_r[erw_pkg::B_FULL_MARK_FLAG])
    else $error("full mark flag cleared without decrement");

  a_empty_mark_set: assert property (
    cnt_w <= ewm_w && !rx_pkt_done_in |=> req_r[erw_pkg::B_EMPTY_MARK_FLAG])
    else $error("empty mark flag missed");

  a_empty_mark_clear: assert property (
    rx_pkt_done_in |=> !req_r[erw_pkg::B_EMPTY_MARK_FLAG])
    else $error("empty mark flag kept over increment");

  a_empty_mark_hold: assert property (
    req_r[erw_pkg::B_EMPTY_MARK_FLAG] && !rx_pkt_done_in |=> req_r[erw_pkg::B_EMPTY_MARK_FLAG])
    else $error("empty mark flag cleared without increment");

  a_txbus_err_set: assert property (
    tx_bus_error_in |=> req_r[erw_pkg::B_TX_BUS_ERROR_FLAG])
    else $error("tx bus error flag missed");

  a_rxbus_err_set: assert property (
    rx_bus_error_in |=> req_r[erw_pkg::B_RX_BUS_ERROR_FLAG])
    else $error("rx bus error flag missed");

  a_rx_done_set: assert property (
    rx_pkt_done_in |=> req_r[erw_pkg::B_RX_DONE_FLAG])
    else $error("rx done flag missed");

  a_overflow_set: assert property (
    rx_overflow_in |=> req_r[erw_pkg::B_RX_OVERFLOW_FLAG])
    else $error("overflow flag missed");

  a_pending_count: assert property (
    cnt_w != 8'h00 && !dec_w |=> req_r[erw_pkg::B_PACKET_PENDING_FLAG])
    else $error("pending flag low with count nonzero");

  a_count_both_hold: assert property (
    rx_pkt_done_in && dec_w && !rx_count_clear_in |=> $stable(cnt_w))
    else $error("count moved on increment with decrement");

  a_count_sat_top: assert property (
    cnt_w == 8'hFF && rx_pkt_done_in && !dec_w && !rx_count_clear_in
    |=> cnt_w == 8'hFF)
    else $error("count rolled over");

  a_reserved_zero: assert property (
    (rd_data_w & ~erw_pkg::FLAG_MASK) == 32'h00000000
    || sel(rd_addr_w, erw_pkg::OFF_WM) || sel(rd_addr_w, erw_pkg::OFF_STAT))
    else $error("reserved bits read nonzero");

  a_irq_enabled: assert property (
    $rose(req_r[erw_pkg::B_RX_DONE_FLAG]) && en_r[erw_pkg::B_RX_DONE_FLAG] |-> irq_out)
    else $error("interrupt missing for enabled flag");

  a_wm_write: assert property (
    wr_wm_w && wr_addr_w[3:2] == 2'b00 && wr_strb_w[2]
    |=> fwm_w == $past(wr_data_w[23:16]))
    else $error("full watermark not stored");

  c_full_reached: cover property (
    !req_r[erw_pkg::B_FULL_MARK_FLAG] ##1 req_r[erw_pkg::B_FULL_MARK_FLAG]);
  c_full_cleared: cover property (
    req_r[erw_pkg::B_FULL_MARK_FLAG] && dec_w ##1 !req_r[erw_pkg::B_FULL_MARK_FLAG]);
  c_irq_rise: cover property ($rose(irq_out));
  c_flow_ctrl: cover property ($rose(fc_r) ##[1:200] $fell(fc_r));
endmodule : erw_rx_watermark_irq
`default_nettype wire

/* File: verilog/erw_pkg.sv */
`default_nettype none
package erw_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_WM   = 8'h00;
  localparam logic [7:0] OFF_EN   = 8'h10;
  localparam logic [7:0] OFF_REQ  = 8'h20;
  localparam logic [7:0] OFF_CTRL = 8'h30;
  localparam logic [7:0] OFF_STAT = 8'h40;
  // Alias operations in address bits 3:2
  typedef enum logic [1:0] {
    ALIAS_WRITE = 2'b00,
    ALIAS_SET   = 2'b01,
    ALIAS_CLR   = 2'b10,
    ALIAS_INV   = 2'b11
  } erw_alias_t;
  // Field positions
  localparam int FWM_LSB      = 16;
  localparam int EWM_LSB      = 0;
  localparam int STAT_CNT_LSB = 16;
  localparam int B_TX_BUS_ERROR_FLAG     = 14;
  localparam int B_RX_BUS_ERROR_FLAG     = 13;
  localparam int B_EMPTY_MARK_FLAG     = 9;
  localparam int B_FULL_MARK_FLAG     = 8;
  localparam int B_RX_DONE_FLAG     = 7;
  localparam int B_PACKET_PENDING_FLAG    = 6;
  localparam int B_RX_ACTIVITY_FLAG      = 5;
  localparam int B_TX_DONE_FLAG     = 3;
  localparam int B_TX_ABORT_FLAG    = 2;
  localparam int B_RX_DESCRIPTOR_MISSING_FLAG    = 1;
  localparam int B_RX_OVERFLOW_FLAG    = 0;
  localparam int CTRL_DEC     = 0;
  localparam int CTRL_AUTOFC  = 1;
  // Implemented bits
  localparam logic [31:0] WM_MASK   = 32'h00FF00FF;
  localparam logic [31:0] FLAG_MASK = 32'h000063EF;
  localparam logic [31:0] EVT_MASK  = 32'h000060AF;
  localparam logic [31:0] CTRL_MASK = 32'h00000002;
  // Reset values
  localparam logic [31:0] WM_RST   = 32'h00000000;
  localparam logic [31:0] EN_RST   = 32'h00000000;
  localparam logic [31:0] REQ_RST  = 32'h00000000;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [7:0]  CNT_RST  = 8'h00;
  localparam logic [7:0]  CNT_MAX  = 8'hFF;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : erw_pkg
`default_nettype wire

/* File: verilog/erw_buf_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module erw_buf_counter (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       resetn_in,
  // Count control
  input  wire logic       inc_in,
  input  wire logic [7:0] inc_amount_in,
  input  wire logic       dec_in,
  input  wire logic       clear_in,
  // Count value
  output logic      [7:0] count_out
);
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic [8:0] sum_w;

  assign sum_w = {1'b0, count_r} + {1'b0, inc_amount_in};

  // Saturating up and down, both at once hold
  always_comb
  begin
    count_nxt = count_r;
    if (clear_in)
      count_nxt = erw_pkg::CNT_RST;
    else if (inc_in && !dec_in)
      count_nxt = sum_w[8] ? erw_pkg::CNT_MAX : sum_w[7:0];
    else if (dec_in && !inc_in && count_r != erw_pkg::CNT_RST)
      count_nxt = count_r - 8'h01;
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
      count_r <= erw_pkg::CNT_RST;
    else
      count_r <= count_nxt;
  end

  assign count_out = count_r;
endmodule : erw_buf_counter
`default_nettype wire

/* File: verilog/erw_axil_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module erw_axil_slave (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  // AXI4-Lite write
  input  wire logic [7:0]  awaddr_in,
  input  wire logic        awvalid_in,
  output logic             awready_out,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wstrb_in,
  input  wire logic        wvalid_in,
  output logic             wready_out,
  output logic [1:0]       bresp_out,
  output logic             bvalid_out,
  input  wire logic        bready_in,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr_in,
  input  wire logic        arvalid_in,
  output logic             arready_out,
  output logic [31:0]      rdata_out,
  output logic [1:0]       rresp_out,
  output logic             rvalid_out,
  input  wire logic        rready_in,
  // Register file side
  output logic             wr_en_out,
  output logic [7:0]       wr_addr_out,
  output logic [31:0]      wr_data_out,
  output logic [3:0]       wr_strb_out,
  input  wire logic        wr_ok_in,
  output logic [7:0]       rd_addr_out,
  input  wire logic [31:0] rd_data_in,
  input  wire logic        rd_ok_in
);
  logic        aw_r;
  logic        w_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic        aw_hs_w;
  logic        w_hs_w;
  logic        ar_hs_w;

  assign awready_out = !aw_r && !bvalid_r;
  assign wready_out  = !w_r && !bvalid_r;
  assign arready_out = !rvalid_r;
  assign aw_hs_w     = awvalid_in && awready_out;
  assign w_hs_w      = wvalid_in && wready_out;
  assign ar_hs_w     = arvalid_in && arready_out;
  assign wr_en_out   = aw_r && w_r && !bvalid_r;
  assign wr_addr_out = awaddr_r;
  assign wr_data_out = wdata_r;
  assign wr_strb_out = wstrb_r;
  assign rd_addr_out = araddr_in;

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      aw_r     <= 1'b0;
      w_r      <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r  <= 32'h00000000;
      wstrb_r  <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r  <= erw_pkg::RESP_OKAY;
    end
    else
    begin
      if (aw_hs_w)
      begin
        aw_r     <= 1'b1;
        awaddr_r <= awaddr_in;
      end
      if (w_hs_w)
      begin
        w_r     <= 1'b1;
        wdata_r <= wdata_in;
        wstrb_r <= wstrb_in;
      end
      if (wr_en_out)
      begin
        aw_r     <= 1'b0;
        w_r      <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= wr_ok_in ? erw_pkg::RESP_OKAY : erw_pkg::RESP_SLVERR;
      end
      else if (bvalid_r && bready_in)
        bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= erw_pkg::RESP_OKAY;
    end
    else if (ar_hs_w)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_data_in;
      rresp_r  <= rd_ok_in ? erw_pkg::RESP_OKAY : erw_pkg::RESP_SLVERR;
    end
    else if (rvalid_r && rready_in)
      rvalid_r <= 1'b0;
  end

  assign bvalid_out = bvalid_r;
  assign bresp_out  = bresp_r;
  assign rvalid_out = rvalid_r;
  assign rdata_out  = rdata_r;
  assign rresp_out  = rresp_r;
endmodule : erw_axil_slave
`default_nettype wire

/* File: dv/erw_dma_model.sv */
`timescale 1ns/1ps
`default_nettype none
module erw_dma_model (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  // Bench command
  input  wire logic        cmd_valid_in,
  input  wire logic [3:0]  cmd_code_in,
  input  wire logic [7:0]  cmd_amount_in,
  // Event strobes, one bit per flag position
  output logic      [15:0] evt_out,
  output logic      [7:0]  desc_used_out
);
  logic pkt_done;

  assign pkt_done = cmd_valid_in && (cmd_code_in == 4'h7);

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      evt_out       <= 16'h0000;
      desc_used_out <= 8'h00;
    end
    else
    begin
      evt_out       <= cmd_valid_in ? (16'h0001 << cmd_code_in) : 16'h0000;
      // Count valid only beside a done pulse, scrambled otherwise
      desc_used_out <= pkt_done ? cmd_amount_in : ~desc_used_out;
    end
  end
endmodule : erw_dma_model
`default_nettype wire

/* File: dv/erw_rx_watermark_irq_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module erw_rx_watermark_irq_bench;
  typedef struct {logic [3:0] code; logic [31:0] req;} erw_row_t;
  logic        clk_sys_in, resetn_in, awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in;
  logic        awready_out, wready_out, bvalid_out, arready_out, rvalid_out, cmd_valid;
  logic        flow_control_out, rx_halt_out, irq_out;
  logic [1:0]  bresp_out, rresp_out, resp;
  logic [3:0]  wstrb_in, cmd_code;
  logic [7:0]  awaddr_in, araddr_in, rx_buffer_count_out, cmd_amount, desc_used;
  logic [15:0] evt;
  logic [31:0] wdata_in, rdata_out, data;
  int          fails, n_tests;
  erw_row_t    rows [8];

  erw_rx_watermark_irq u_erw_rx_watermark_irq (
    .clk_sys_in, .resetn_in, .awaddr_in, .awvalid_in, .awready_out, .wdata_in, .wstrb_in,
    .wvalid_in, .wready_out, .bresp_out, .bvalid_out, .bready_in, .araddr_in, .arvalid_in,
    .arready_out, .rdata_out, .rresp_out, .rvalid_out, .rready_in,
    .rx_pkt_done_in(evt[7]), .rx_desc_used_in(desc_used), .rx_activity_in(evt[5]),
    .rx_desc_missing_in(evt[1]), .rx_overflow_in(evt[0]), .rx_bus_error_in(evt[13]),
    .tx_bus_error_in(evt[14]), .tx_done_in(evt[3]), .tx_abort_in(evt[2]),
    .rx_count_clear_in(evt[15]), .rx_buffer_count_out, .flow_control_out, .rx_halt_out,
    .irq_out
  );

  erw_dma_model u_erw_dma_model (
    .clk_sys_in, .resetn_in, .cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code),
    .cmd_amount_in(cmd_amount), .evt_out(evt), .desc_used_out(desc_used)
  );

  always #12.5 clk_sys_in = ~clk_sys_in;

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr_in  <= a;
    wdata_in   <= d;
    awvalid_in <= 1'b1;
    wvalid_in  <= 1'b1;
    do
    begin
      @(posedge clk_sys_in);
      if (awvalid_in && awready_out) awvalid_in <= 1'b0;
      if (wvalid_in && wready_out) wvalid_in <= 1'b0;
    end
    while (!bvalid_out);
    resp = bresp_out;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    araddr_in  <= a;
    arvalid_in <= 1'b1;
    do
    begin
      @(posedge clk_sys_in);
      if (arvalid_in && arready_out) arvalid_in <= 1'b0;
    end
    while (!rvalid_out);
    data = rdata_out;
    resp = rresp_out;
  endtask : rd

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(n, e, data);
    chk(n, {30'h0, erw_pkg::RESP_OKAY}, {30'h0, resp});
  endtask : rchk

  task automatic ev(input logic [3:0] c, input logic [7:0] n);
    cmd_code   <= c;
    cmd_amount <= n;
    cmd_valid  <= 1'b1;
    @(posedge clk_sys_in);
    cmd_valid  <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
  endtask : ev

  task automatic done(input string n);
    $display("test %s finished", n);
  endtask : done

  initial
  begin
    repeat (6000) @(posedge clk_sys_in);
    fails++;
    summarize();
  end

  initial
  begin
    clk_sys_in = 1'b0;
    resetn_in  = 1'b0;
    {awvalid_in, wvalid_in, arvalid_in, cmd_valid} = 4'h0;
    {bready_in, rready_in} = 2'b11;
    wstrb_in   = 4'hF;
    {awaddr_in, araddr_in, cmd_code, cmd_amount} = 28'h0;
    wdata_in   = 32'h0;
    fails      = 0;
    n_tests    = 0;
    rows = '{'{4'h0, 32'h301}, '{4'h1, 32'h302}, '{4'h2, 32'h304}, '{4'h3, 32'h308},
             '{4'h5, 32'h320}, '{4'h7, 32'h380}, '{4'hD, 32'h2300}, '{4'hE, 32'h4300}};
    repeat (10) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    @(posedge clk_sys_in);
    rchk("wm reset", 8'h00, 32'h0);
    rchk("en reset", 8'h10, 32'h0);
    rchk("req reset", 8'h20, 32'h300);
    done("reset");
    foreach (rows[i])
    begin
      wr(8'h10, 32'h0);
      ev(rows[i].code, 8'h00);
      rchk("req event", 8'h20, rows[i].req);
      chk("irq masked", 32'h0, {31'h0, irq_out});
      wr(8'h10, rows[i].req & 32'hFCFF);
      chk("irq enabled", 32'h1, {31'h0, irq_out});
      wr(8'h28, rows[i].req & 32'hFCFF);
      rchk("req cleared", 8'h20, 32'h300);
      chk("irq cleared", 32'h0, {31'h0, irq_out});
    end
    done("event rows");
    wr(8'h10, 32'hFFFFFFFF);
    rchk("en all", 8'h10, 32'h63EF);
    wr(8'h18, 32'h6000);
    wr(8'h1C, 32'h0001);
    wr(8'h14, 32'h4000);
    rchk("en alias", 8'h10, 32'h43EE);
    wr(8'h00, 32'hFFFFFFFF);
    rchk("wm all", 8'h00, 32'h00FF00FF);
    wr(8'h00, 32'h00030001);
    rchk("wm set", 8'h00, 32'h00030001);
    wr(8'h30, 32'h2);
    rchk("ctrl", 8'h30, 32'h2);
    done("registers");
    wr(8'h34, 32'h1);
    rchk("req full clear", 8'h20, 32'h200);
    wr(8'h10, 32'h100);
    ev(4'h7, 8'h02);
    rchk("req two", 8'h20, 32'h0C0);
    chk("irq below full", 32'h0, {31'h0, irq_out});
    ev(4'h7, 8'h01);
    rchk("req full", 8'h20, 32'h1C0);
    chk("irq full", 32'h1, {31'h0, irq_out});
    chk("flow on", 32'h1, {31'h0, flow_control_out});
    wr(8'h20, 32'h0);
    rchk("req direct", 8'h20, 32'h140);
    wr(8'h34, 32'h1);
    rchk("count dec", 8'h40, 32'h00020000);
    rchk("req dec", 8'h20, 32'h040);
    wr(8'h30, 32'h3);
    wr(8'h30, 32'h3);
    wr(8'h30, 32'h3);
    rchk("count floor", 8'h40, 32'h0);
    rchk("req empty", 8'h20, 32'h200);
    chk("flow off", 32'h0, {31'h0, flow_control_out});
    done("watermarks");
    ev(4'h7, 8'hFF);
    ev(4'h7, 8'hFF);
    rchk("count sat", 8'h40, 32'h00FF0000);
    rchk("req sat", 8'h20, 32'h1C0);
    chk("halt", 32'h1, {31'h0, rx_halt_out});
    ev(4'hF, 8'h00);
    rchk("count clear", 8'h40, 32'h0);
    ev(4'h7, 8'h05);
    fork
      wr(8'h34, 32'h1);
      ev(4'h7, 8'h03);
    join
    rchk("count both", 8'h40, 32'h00050000);
    done("saturation");
    rd(8'h50);
    chk("unmapped data", 32'h0, data);
    chk("unmapped rd", {30'h0, erw_pkg::RESP_SLVERR}, {30'h0, resp});
    wr(8'h50, 32'hFFFFFFFF);
    chk("unmapped wr", {30'h0, erw_pkg::RESP_SLVERR}, {30'h0, resp});
    done("unmapped");
    wr(8'h28, 32'h80);
    wr(8'h10, 32'hC0);
    ev(4'h7, 8'h05);
    chk("irq pend", 32'h1, {31'h0, irq_out});
    resetn_in <= 1'b0;
    @(posedge clk_sys_in);
    chk("irq in reset", 32'h0, {31'h0, irq_out});
    chk("count in reset", 32'h0, {24'h0, rx_buffer_count_out});
    repeat (2) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    @(posedge clk_sys_in);
    rchk("wm second reset", 8'h00, 32'h0);
    done("second reset");
    summarize();
  end
endmodule : erw_rx_watermark_irq_bench
`default_nettype wire
